/* File: hw/bwc_regs.sv */
module bwc_regs
  import bwc_pkg::*;
(
  input wire logic clk_sys_in,            // 50 MHz clock.
  input wire logic rstn_in,               // Synchronous reset, active low.
  input wire logic pcie_side_in,          // High selects the PCI Express pointer value.
  input wire logic [7:0] addr_in,         // Register byte address.
  input wire logic [31:0] wdata_in,       // Write data.
  input wire logic wr_in,                 // Write strobe.
  input wire logic rd_in,                 // Read strobe.
  output logic [31:0] rdata_out,          // Read data, cycle after strobe.
  input wire logic ee_load_in,            // EEPROM preload strobe.
  input wire logic [7:0] ee_addr_in,      // EEPROM preload address.
  input wire logic [31:0] ee_data_in,     // EEPROM preload data.
  input wire logic req_valid_in,          // Memory request strobe.
  input wire logic req_from_down_in,      // High when request comes from downstream.
  input wire logic req_prefetch_in,       // Request is prefetchable memory.
  input wire logic [63:0] req_addr_in,    // Request address.
  output logic fwd_valid_out,             // Decision is valid.
  output logic fwd_out,                   // Forward the request.
  output logic [63:0] pf_base_out,        // Full prefetchable base.
  output logic [63:0] pf_limit_out,       // Full prefetchable limit.
  output logic [31:0] io_base_hi_out,     // I/O base address 31:16 in high half.
  output logic [31:0] io_limit_hi_out,    // I/O limit address 31:16 in high half.
  output logic pf_inverted_out            // Prefetchable window inverted.
);
  logic [3:0] base_cap_reg;
  logic [3:0] limit_cap_reg;
  logic [11:0] base_addr_reg;
  logic [11:0] limit_addr_reg;
  logic [31:0] base_upper_reg;
  logic [31:0] limit_upper_reg;
  logic [15:0] io_base_reg;
  logic [15:0] io_limit_reg;
  logic [31:0] rdata_next;
  logic [63:0] base_full;
  logic [63:0] limit_full;
  logic hit;
  logic inverted;
  logic wr_any;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic base_is_64;
  logic limit_is_64;

  // A configuration write wins over an EEPROM load in the same cycle.
  always_comb begin
    wr_any = wr_in || ee_load_in;
    wr_addr = wr_in ? addr_in : ee_addr_in;
    wr_data = wr_in ? wdata_in : ee_data_in;
    base_is_64 = base_cap_reg == BWC_CAP_64BIT;
    limit_is_64 = limit_cap_reg == BWC_CAP_64BIT;
  end

  // Capability fields are read-only to software; only the preload changes them.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      base_cap_reg <= BWC_CAP_RESET;
      limit_cap_reg <= BWC_CAP_RESET;
    end else if (ee_load_in && ee_addr_in == BWC_OFF_PF_BASE_LIMIT) begin
      base_cap_reg <= (ee_data_in[BWC_BASE_CAP_LSB +: 4] == BWC_CAP_32BIT)
        ? BWC_CAP_32BIT : BWC_CAP_64BIT;
      limit_cap_reg <= (ee_data_in[BWC_LIMIT_CAP_LSB +: 4] == BWC_CAP_32BIT)
        ? BWC_CAP_32BIT : BWC_CAP_64BIT;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      base_addr_reg <= BWC_ADDR12_RESET;
      limit_addr_reg <= BWC_ADDR12_RESET;
    end else if (wr_any && wr_addr == BWC_OFF_PF_BASE_LIMIT) begin
      base_addr_reg <= wr_data[BWC_BASE_ADDR_LSB +: 12];
      limit_addr_reg <= wr_data[BWC_LIMIT_ADDR_LSB +: 12];
    end
  end

  // Upper halves are held at zero while their side is 32-bit.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      base_upper_reg <= BWC_WORD_RESET;
    end else if (!base_is_64) begin
      base_upper_reg <= BWC_WORD_RESET;
    end else if (wr_any && wr_addr == BWC_OFF_PF_BASE_UPPER) begin
      base_upper_reg <= wr_data;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      limit_upper_reg <= BWC_WORD_RESET;
    end else if (!limit_is_64) begin
      limit_upper_reg <= BWC_WORD_RESET;
    end else if (wr_any && wr_addr == BWC_OFF_PF_LIMIT_UPPER) begin
      limit_upper_reg <= wr_data;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      io_base_reg <= BWC_WORD_RESET[15:0];
      io_limit_reg <= BWC_WORD_RESET[31:16];
    end else if (wr_any && wr_addr == BWC_OFF_IO_UPPER) begin
      io_base_reg <= wr_data[15:0];
      io_limit_reg <= wr_data[31:16];
    end
  end

  always_comb begin
    base_full = {base_upper_reg, base_addr_reg, BWC_BASE_LOW_FILL};
    limit_full = {limit_upper_reg, limit_addr_reg, BWC_LIMIT_LOW_FILL};
  end

  bwc_window_match u_match (
    .addr_in(req_addr_in),
    .base_in(base_full),
    .limit_in(limit_full),
    .hit_out(hit),
    .inverted_out(inverted)
  );

  // Unmapped addresses read zero.
  always_comb begin
    rdata_next = BWC_WORD_RESET;
    case (addr_in)
      BWC_OFF_PF_BASE_LIMIT: begin
        rdata_next = {limit_addr_reg, limit_cap_reg, base_addr_reg, base_cap_reg};
      end
      BWC_OFF_PF_BASE_UPPER: begin
        rdata_next = base_upper_reg;
      end
      BWC_OFF_PF_LIMIT_UPPER: begin
        rdata_next = limit_upper_reg;
      end
      BWC_OFF_IO_UPPER: begin
        rdata_next = {io_limit_reg, io_base_reg};
      end
      BWC_OFF_CAP_PTR: begin
        rdata_next = {24'h000000, pcie_side_in ? BWC_CAP_PTR_PCIE : BWC_CAP_PTR_PCIX};
      end
      BWC_OFF_EXP_ROM: begin
        rdata_next = BWC_WORD_RESET;
      end
      default: begin
        rdata_next = BWC_WORD_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      rdata_out <= BWC_WORD_RESET;
    end else if (rd_in) begin
      rdata_out <= rdata_next;
    end else begin
      rdata_out <= BWC_WORD_RESET;
    end
  end

  // Forwarding decision, one cycle after the request.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      fwd_valid_out <= 1'b0;
      fwd_out <= 1'b0;
    end else begin
      fwd_valid_out <= req_valid_in;
      if (!req_valid_in) begin
        fwd_out <= 1'b0;
      end else if (req_from_down_in) begin
        fwd_out <= 1'b1;
      end else if (req_prefetch_in) begin
        fwd_out <= !inverted && hit;
      end else begin
        fwd_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      pf_base_out <= {BWC_WORD_RESET, BWC_WORD_RESET};
      pf_limit_out <= {BWC_WORD_RESET, BWC_WORD_RESET};
      io_base_hi_out <= BWC_WORD_RESET;
      io_limit_hi_out <= BWC_WORD_RESET;
      pf_inverted_out <= 1'b0;
    end else begin
      pf_base_out <= base_full;
      pf_limit_out <= limit_full;
      io_base_hi_out <= {io_base_reg, 16'h0000};
      io_limit_hi_out <= {io_limit_reg, 16'h0000};
      pf_inverted_out <= inverted;
    end
  end
endmodule : bwc_regs

/* File: hw/bwc_pkg.sv */
package bwc_pkg;
  localparam logic [7:0] BWC_OFF_PF_BASE_LIMIT = 8'h24;
  localparam logic [7:0] BWC_OFF_PF_BASE_UPPER = 8'h28;
  localparam logic [7:0] BWC_OFF_PF_LIMIT_UPPER = 8'h2c;
  localparam logic [7:0] BWC_OFF_IO_UPPER = 8'h30;
  localparam logic [7:0] BWC_OFF_CAP_PTR = 8'h34;
  localparam logic [7:0] BWC_OFF_EXP_ROM = 8'h38;
  localparam int BWC_BASE_CAP_LSB = 0;
  localparam int BWC_BASE_ADDR_LSB = 4;
  localparam int BWC_LIMIT_CAP_LSB = 16;
  localparam int BWC_LIMIT_ADDR_LSB = 20;
  localparam logic [3:0] BWC_CAP_32BIT = 4'h0;
  localparam logic [3:0] BWC_CAP_64BIT = 4'h1;
  localparam logic [3:0] BWC_CAP_RESET = 4'h1;
  localparam logic [11:0] BWC_ADDR12_RESET = 12'h000;
  localparam logic [31:0] BWC_WORD_RESET = 32'h0000_0000;
  localparam logic [19:0] BWC_BASE_LOW_FILL = 20'h00000;
  localparam logic [19:0] BWC_LIMIT_LOW_FILL = 20'hfffff;
  localparam logic [7:0] BWC_CAP_PTR_PCIX = 8'h48;
  localparam logic [7:0] BWC_CAP_PTR_PCIE = 8'h40;
endpackage : bwc_pkg

/* File: hw/bwc_window_match.sv */
module bwc_window_match
  import bwc_pkg::*;
(
  input wire logic [63:0] addr_in,   // Request address.
  input wire logic [63:0] base_in,   // Window base.
  input wire logic [63:0] limit_in,  // Window limit.
  output logic hit_out,              // Address inside window.
  output logic inverted_out          // Limit below base.
);
  always_comb begin
    inverted_out = limit_in < base_in;
    hit_out = (addr_in >= base_in) && (addr_in <= limit_in);
  end
endmodule : bwc_window_match

/* File: verif/bwc_ee_model.sv */
module bwc_ee_model (
  input wire logic clk_in, // Clock.
  input wire logic go_in, // Load command.
  input wire logic [7:0] a_in, // Offset.
  input wire logic [31:0] d_in, // Word.
  output logic ee_load_out, // Strobe.
  output logic [7:0] ee_addr_out = 8'h00, // Offset.
  output logic [31:0] ee_data_out = 32'h0 // Word.
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle lines toggle so a stale word is never taken for a load.
  always @(posedge clk_in) begin
    ee_load_out <= go_in;
    ee_addr_out <= go_in ? a_in : ~ee_addr_out;
    ee_data_out <= go_in ? d_in : ~ee_data_out;
  end
endmodule : bwc_ee_model

/* File: verif/bwc_regs_properties.sv */
module bwc_regs_props (
  input wire logic clk_sys_in, // Clock.
  input wire logic rstn_in, // Reset.
  input wire logic pcie_side_in, // Side.
  input wire logic [7:0] addr_in, // Offset.
  input wire logic rd_in, // Read.
  input wire logic [31:0] rdata_out, // Data.
  input wire logic req_valid_in, // Request.
  input wire logic req_from_down_in, // Origin.
  input wire logic req_prefetch_in, // Kind.
  input wire logic [63:0] req_addr_in, // Address.
  input wire logic fwd_out, // Decision.
  input wire logic [63:0] pf_base_out, // Base.
  input wire logic [63:0] pf_limit_out, // Limit.
  input wire logic [31:0] io_base_hi_out, // I/O base.
  input wire logic [31:0] io_limit_hi_out // I/O limit.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  sequence s_up;
    req_valid_in && !req_from_down_in && req_prefetch_in;
  endsequence
  chk_down_fwd: assert property (req_valid_in && req_from_down_in |=> fwd_out)
    else $error("downstream request dropped");
  // The window outputs lag the decoder by one edge, so both are judged a cycle later.
  chk_inv_block: assert property (s_up |=> (pf_base_out > pf_limit_out |-> !fwd_out))
    else $error("inverted window forwarded");
  chk_in_win: assert property (s_up |=> fwd_out == ($past(req_addr_in) >= pf_base_out
    && $past(req_addr_in) <= pf_limit_out && pf_base_out <= pf_limit_out))
    else $error("prefetchable decision wrong");
  chk_rdata_idle: assert property (!rd_in |=> rdata_out == 32'h0)
    else $error("read data outside read slot");
  chk_base_low: assert property (pf_base_out[19:0] == 20'h00000)
    else $error("base low bits set");
  chk_limit_low: assert property ($past(rstn_in) |-> pf_limit_out[19:0] == 20'hfffff)
    else $error("limit low bits clear");
  chk_cap_ptr: assert property (rd_in && addr_in == 8'h34 |=>
    rdata_out == ($past(pcie_side_in) ? 32'h40 : 32'h48))
    else $error("capability pointer wrong");
  chk_rom_zero: assert property (rd_in && addr_in == 8'h38 |=> rdata_out == 32'h0)
    else $error("rom base not zero");
  chk_io_half: assert property (rd_in && addr_in == 8'h30 |=>
    rdata_out == {io_limit_hi_out[31:16], io_base_hi_out[31:16]})
    else $error("io halves differ");
endmodule : bwc_regs_props
bind bwc_regs bwc_regs_props i_chk (.clk_sys_in, .rstn_in, .pcie_side_in, .addr_in, .rd_in,
  .rdata_out, .req_valid_in, .req_from_down_in, .req_prefetch_in, .req_addr_in, .fwd_out,
  .pf_base_out, .pf_limit_out, .io_base_hi_out, .io_limit_hi_out);

/* File: verif/bwc_regs_tb.sv */
`define CHK(n, e, a) begin logic [63:0] x; x = e; checks++; if ((a) !== x) begin \
  n_mismatch++; $display("mismatch %s exp %h seen %h", n, x, a); end end
module bwc_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 0, rstn_in = 0, pcie_side_in = 0, wr_in = 0, rd_in = 0, eg = 0, rd_d = 0;
  logic req_valid_in = 0, req_from_down_in = 0, req_prefetch_in = 0, cb = 1, cl = 1;
  logic ee_load_in, fwd_valid_out, fwd_out, pf_inverted_out;
  logic [7:0] addr_in = 0, ee_addr_in;
  logic [11:0] bf = 0, lf = 0;
  logic [31:0] wdata_in = 0, ee_data_in, rdata_out, io_base_hi_out, io_limit_hi_out;
  logic [31:0] bu = 0, lu = 0, io = 0, seed = 32'h8ee079e3;
  logic [63:0] req_addr_in = 0, pf_base_out, pf_limit_out;
  logic [31:0] rq[$];
  logic fq[$];
  int n_mismatch = 0, checks = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  bwc_regs i_dut (.clk_sys_in, .rstn_in, .pcie_side_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .ee_load_in, .ee_addr_in, .ee_data_in, .req_valid_in, .req_from_down_in,
    .req_prefetch_in, .req_addr_in, .fwd_valid_out, .fwd_out, .pf_base_out, .pf_limit_out,
    .io_base_hi_out, .io_limit_hi_out, .pf_inverted_out);
  bwc_ee_model i_ee (.clk_in(clk_sys_in), .go_in(eg), .a_in(addr_in), .d_in(wdata_in),
    .ee_load_out(ee_load_in), .ee_addr_out(ee_addr_in), .ee_data_out(ee_data_in));
  task automatic step(logic w, logic r, logic q, logic [7:0] a, logic [31:0] d,
    logic [63:0] ra = 0, logic dn = 0, logic pf = 1, logic e = 0);
    {wr_in, rd_in, req_valid_in, eg} <= {w, r, q, e};
    {addr_in, wdata_in, req_addr_in, req_from_down_in, req_prefetch_in} <= {a, d, ra, dn, pf};
    @(posedge clk_sys_in);
  endtask : step
  task automatic wr(logic [7:0] a, logic [31:0] d);
    step(1, 0, 0, a, d);
    if (a == 8'h24) {lf, bf} = {d[31:20], d[15:4]};
    if (a == 8'h28 && cb) bu = d;
    if (a == 8'h2c && cl) lu = d;
    if (a == 8'h30) io = d;
  endtask : wr
  task automatic rd(logic [7:0] a);
    case (a)
      8'h24: rq.push_back({lf, 3'b0, cl, bf, 3'b0, cb});
      8'h28: rq.push_back(bu);
      8'h2c: rq.push_back(lu);
      8'h30: rq.push_back(io);
      8'h34: rq.push_back(pcie_side_in ? 32'h40 : 32'h48);
      default: rq.push_back(32'h0);
    endcase
    step(0, 1, 0, a, 0);
  endtask : rd
  task automatic req(logic [63:0] ra, logic dn, logic pf);
    logic [63:0] b, l;
    b = {bu, bf, 20'h0};
    l = {lu, lf, 20'hfffff};
    fq.push_back(dn || (pf && b <= l && ra >= b && ra <= l));
    step(0, 0, 1, 0, 0, ra, dn, pf);
  endtask : req
  task automatic conclude();
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  always @(posedge clk_sys_in) begin
    rd_d <= rd_in;
    if (rd_d) `CHK("rdata", rq.pop_front(), rdata_out)
    else if (rstn_in) `CHK("rdata_idle", 32'h0, rdata_out)
    if (fwd_valid_out) `CHK("fwd", fq.pop_front(), fwd_out)
  end
  initial begin
    #20us;
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rstn_in <= 1;
    step(0, 0, 0, 0, 0);
    for (int a = 8'h24; a <= 8'h3c; a += 4) rd(8'(a));
    pcie_side_in <= 1;
    step(0, 0, 0, 0, 0);
    rd(8'h34);
    repeat (3) begin
      for (int a = 8'h24; a <= 8'h38; a += 4) wr(8'(a), $random(seed));
      for (int a = 8'h24; a <= 8'h38; a += 4) rd(8'(a));
    end
    `CHK("io_base", {io[15:0], 16'h0}, io_base_hi_out)
    `CHK("io_limit", {io[31:16], 16'h0}, io_limit_hi_out)
    wr(8'h24, 32'h0400_0020);
    wr(8'h28, 32'h1);
    wr(8'h2c, 32'h1);
    for (int i = -1; i < 2; i++) req({bu, bf, 20'h0} + 64'(i), 0, 1);
    for (int i = -1; i < 2; i++) req({lu, lf, 20'hfffff} + 64'(i), 0, 1);
    req(64'h0030_0000, 0, 1);
    repeat (8) req({32'h1, 6'h0, 26'($random(seed))}, 1'($random(seed)), 1'($random(seed)));
    wr(8'h24, 32'h0010_0200);
    req({32'h1, 32'h0020_0000}, 0, 1);
    req({32'h1, 32'h0020_0000}, 1, 1);
    req({32'h1, 32'h0020_0000}, 1, 0);
    `CHK("inverted", 1'b1, pf_inverted_out)
    `CHK("pf_base", {bu, bf, 20'h0}, pf_base_out)
    `CHK("pf_limit", {lu, lf, 20'hfffff}, pf_limit_out)
    step(0, 0, 0, 8'h24, 32'hfff0_0000, 0, 0, 1, 1);
    step(0, 0, 0, 8'h28, 32'hffff_ffff, 0, 0, 1, 1);
    step(0, 0, 0, 0, 0);
    {cb, cl, bu, lu, lf, bf} = {2'b0, 64'h0, 12'hfff, 12'h000};
    wr(8'h28, $random(seed));
    wr(8'h2c, $random(seed));
    for (int a = 8'h24; a <= 8'h2c; a += 4) rd(8'(a));
    req(64'h8000_0000, 0, 1);
    req({32'h1, 32'h0}, 0, 1);
    step(0, 0, 0, 0, 0);
    step(0, 0, 0, 0, 0);
    conclude();
  end
endmodule : bwc_regs_tb
